// File: common/ptimer_pkg.sv
// Constants shared by the period match timer and its prescaler.
package ptimer_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_COUNT = 8'h00;
    localparam logic [7:0] OFF_PERIOD = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    // Control register field positions.
    localparam int CTRL_PRE_LSB = 0;
    localparam int CTRL_PRE_MSB = 1;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_POST_LSB = 3;
    localparam int CTRL_POST_MSB = 6;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;
    // Status and mask register field position.
    localparam int MATCH_BIT = 0;
    // Reset values.
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Last prescaler count for each division ratio.
    localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
    localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;

    // Maps the prescale select field onto the last count of the divider.
    function automatic logic [3:0] pre_last(input logic [1:0] sel);
        logic [3:0] last;
        last = PRE_LAST_DIV16;
        if (sel == 2'h0) begin
            last = PRE_LAST_DIV1;
        end else if (sel == 2'h1) begin
            last = PRE_LAST_DIV4;
        end
        return last;
    endfunction : pre_last
endpackage : ptimer_pkg

// File: common/prescale_if.sv
// Signals passed between the timer core and its prescaler.
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
    logic clear;
    logic run;
    logic [1:0] sel;
    logic tick;
    modport core (output clear, output run, output sel, input tick);
    modport divider (input clear, input run, input sel, output tick);
endinterface : prescale_if
`default_nettype wire

// File: hw/prescaler.sv
// Prescaler that turns instruction clocks into count increment ticks.
`timescale 1ns/1ps
`default_nettype none
module prescaler (
    input wire logic pclk,
    input wire logic presetn,
    prescale_if.divider pif
);
    logic [3:0] pre_cnt_q;
    logic [3:0] pre_cnt_d;
    logic tick;
    logic at_last;

    // Counts up to the selected last value and wraps; a clear restarts it.
    always_comb begin
        at_last = (pre_cnt_q >= ptimer_pkg::pre_last(pif.sel));
        tick = pif.run && !pif.clear && at_last;
        pre_cnt_d = pre_cnt_q;
        if (pif.clear) begin
            pre_cnt_d = 4'h0;
        end else if (pif.run) begin
            pre_cnt_d = at_last ? 4'h0 : pre_cnt_q + 4'h1;
        end
    end

    // Registers the divider count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 4'h0;
        end else begin
            pre_cnt_q <= pre_cnt_d;
        end
    end

    assign pif.tick = tick;

    property p_pre_clear;
        @(posedge pclk) disable iff (!presetn)
        pif.clear |=> (pre_cnt_q == 4'h0);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

    property p_pre_div16;
        @(posedge pclk) disable iff (!presetn)
        (pif.sel[1] && tick) |-> (pre_cnt_q == 4'hF);
    endproperty
    a_pre_div16: assert property (p_pre_div16) else $error("divide by 16 wrong");
endmodule : prescaler
`default_nettype wire

// File: hw/period_match_timer8.sv
// Eight-bit period match timer with prescaler, postscaler and APB registers.
//
// What this block does
// - Instruction clock divided by one, four, sixteen.
// - Count climbs from zero, restarts after period match.
// - Every match advances the postscaler.
// - Postscaler at ratio sets the match flag.
// - Count and period readable and writable always.
// - Reset loads count zero, period all ones.
// - Counting happens only while run enable set.
// - Count or control writes clear both scalers.
// - Control writes leave the count untouched.
// - Postscale field plus one gives the ratio.
// - Prescale field: 00 one, 01 four, 1x sixteen.
// - Control bit seven ignores writes, reads zero.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    // Register state.
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] period_q;
    logic [7:0] period_d;
    logic [7:0] control_q;
    logic [7:0] control_d;
    logic [3:0] post_cnt_q;
    logic [3:0] post_cnt_d;
    logic flag_q;
    logic flag_d;
    logic enable_q;
    logic enable_d;
    logic irq_q;
    logic irq_d;

    // Bus answer state.
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // Decoded strobes and timer events.
    logic access_first;
    logic access_done;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_status;
    logic wr_mask;
    logic scaler_clear;
    logic at_period;
    logic match_ev;
    logic post_hit;
    logic tick;

    prescale_if pif ();

    // The prescaler turns instruction clocks into increment ticks.
    prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .pif(pif)
    );

    // Checks whether an address falls on one of the registers.
    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr == ptimer_pkg::OFF_COUNT) || (addr == ptimer_pkg::OFF_PERIOD) ||
               (addr == ptimer_pkg::OFF_CONTROL) || (addr == ptimer_pkg::OFF_STATUS) ||
               (addr == ptimer_pkg::OFF_MASK);
    endfunction : addr_mapped

    // Reports whether a finished write hits the given offset.
    function automatic logic write_hit(input logic done, input logic wr,
                                       input logic [7:0] addr, input logic [7:0] off);
        return done && wr && (addr == off);
    endfunction : write_hit

    // Bus phase decode; every access carries one wait state.
    always_comb begin
        access_first = psel && penable && !pready_q;
        access_done = psel && penable && pready_q;
        wr_count = write_hit(access_done, pwrite, paddr, ptimer_pkg::OFF_COUNT);
        wr_period = write_hit(access_done, pwrite, paddr, ptimer_pkg::OFF_PERIOD);
        wr_control = write_hit(access_done, pwrite, paddr, ptimer_pkg::OFF_CONTROL);
        wr_status = write_hit(access_done, pwrite, paddr, ptimer_pkg::OFF_STATUS);
        wr_mask = write_hit(access_done, pwrite, paddr, ptimer_pkg::OFF_MASK);
    end

    // Read data and the answer are prepared in the first access cycle.
    always_comb begin
        pready_d = access_first;
        pslverr_d = access_first && !addr_mapped(paddr);
        prdata_d = prdata_q;
        if (access_first && !pwrite) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                ptimer_pkg::OFF_COUNT: prdata_d[7:0] = count_q;
                ptimer_pkg::OFF_PERIOD: prdata_d[7:0] = period_q;
                ptimer_pkg::OFF_CONTROL: prdata_d[7:0] = control_q;
                ptimer_pkg::OFF_STATUS: prdata_d[ptimer_pkg::MATCH_BIT] = flag_q;
                ptimer_pkg::OFF_MASK: prdata_d[ptimer_pkg::MATCH_BIT] = enable_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Registers the bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Drives the prescaler run and select from the control register, and its clear from count or control writes.
    assign scaler_clear = wr_count || wr_control;
    assign pif.clear = scaler_clear;
    assign pif.run = control_q[ptimer_pkg::CTRL_RUN_BIT];
    assign pif.sel = control_q[ptimer_pkg::CTRL_PRE_MSB:ptimer_pkg::CTRL_PRE_LSB];
    assign tick = pif.tick;

    // Match detection against the period register.
    always_comb begin
        at_period = (count_q == period_q);
        match_ev = tick && at_period;
        post_hit = match_ev &&
            (post_cnt_q == control_q[ptimer_pkg::CTRL_POST_MSB:ptimer_pkg::CTRL_POST_LSB]);
    end

    // Next values of the count, period and control registers.
    always_comb begin
        count_d = count_q;
        period_d = period_q;
        control_d = control_q;
        if (wr_count) begin
            count_d = pwdata[7:0];
        end else if (match_ev) begin
            count_d = 8'h00;
        end else if (tick) begin
            count_d = count_q + 8'h01;
        end
        if (wr_period) begin
            period_d = pwdata[7:0];
        end
        if (wr_control) begin
            control_d = pwdata[7:0] & ptimer_pkg::CTRL_WRITE_MASK;
        end
    end

    // Postscaler count; it wraps when the selected ratio is reached.
    always_comb begin
        post_cnt_d = post_cnt_q;
        if (scaler_clear) begin
            post_cnt_d = 4'h0;
        end else if (post_hit) begin
            post_cnt_d = 4'h0;
        end else if (match_ev) begin
            post_cnt_d = post_cnt_q + 4'h1;
        end
    end

    // Sticky match flag, its enable, and the interrupt level.
    always_comb begin
        flag_d = flag_q;
        enable_d = enable_q;
        if (wr_status && pwdata[ptimer_pkg::MATCH_BIT]) begin
            flag_d = 1'b0;
        end
        if (post_hit) begin
            flag_d = 1'b1;
        end
        if (wr_mask) begin
            enable_d = pwdata[ptimer_pkg::MATCH_BIT];
        end
        irq_d = flag_q && enable_q;
    end

    // Registers the timer state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= ptimer_pkg::COUNT_RESET;
            period_q <= ptimer_pkg::PERIOD_RESET;
            control_q <= ptimer_pkg::CONTROL_RESET;
            post_cnt_q <= 4'h0;
            flag_q <= 1'b0;
            enable_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            count_q <= count_d;
            period_q <= period_d;
            control_q <= control_d;
            post_cnt_q <= post_cnt_d;
            flag_q <= flag_d;
            enable_q <= enable_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    // A match tick with no count write in the same cycle.
    sequence s_match_tick;
        tick && at_period && !wr_count;
    endsequence

    // A plain increment tick with no count write.
    sequence s_plain_tick;
        tick && !at_period && !wr_count;
    endsequence

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        s_match_tick |=> (count_q == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not restart");

    property p_incr;
        @(posedge pclk) disable iff (!presetn)
        s_plain_tick |=> (count_q == $past(count_q) + 8'h01);
    endproperty
    a_incr: assert property (p_incr) else $error("count did not advance");

    property p_post_step;
        @(posedge pclk) disable iff (!presetn)
        (match_ev && !post_hit) |=> (post_cnt_q == $past(post_cnt_q) + 4'h1);
    endproperty
    a_post_step: assert property (p_post_step) else $error("postscaler missed");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        post_hit |=> flag_q ##1 (irq == $past(enable_q));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_ratio;
        @(posedge pclk) disable iff (!presetn)
        (flag_d && !flag_q) |->
            (post_cnt_q == control_q[ptimer_pkg::CTRL_POST_MSB:ptimer_pkg::CTRL_POST_LSB]);
    endproperty
    a_ratio: assert property (p_ratio) else $error("flag at wrong ratio");

    property p_stopped;
        @(posedge pclk) disable iff (!presetn)
        (!control_q[ptimer_pkg::CTRL_RUN_BIT] && !wr_count) |=> $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while off");

    property p_ctl_keep;
        @(posedge pclk) disable iff (!presetn)
        wr_control |=> (count_q == $past(count_q)) && (post_cnt_q == 4'h0);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("control write hit count");

    property p_cnt_write;
        @(posedge pclk) disable iff (!presetn)
        wr_count |=> (count_q == $past(pwdata[7:0])) && (post_cnt_q == 4'h0);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

    property p_bit7;
        @(posedge pclk) disable iff (!presetn)
        wr_control |=> (control_q[7] == 1'b0) ##1 (control_q[7] == 1'b0);
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit seven stored");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        irq == ($past(flag_q) && $past(enable_q));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_reset;
        @(posedge pclk)
        $rose(presetn) |-> (period_q == ptimer_pkg::PERIOD_RESET) && (count_q == 8'h00);
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_rw;
        @(posedge pclk) disable iff (!presetn)
        (access_first && !pwrite && paddr == ptimer_pkg::OFF_PERIOD) |=>
            (prdata_q[7:0] == $past(period_q)) && pready;
    endproperty
    a_rw: assert property (p_rw) else $error("period readback wrong");
endmodule : period_match_timer8
`default_nettype wire

// File: dv/period_match_timer8_tb.sv
// Self-checking testbench for the period match timer, driven over APB.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] rd;
    logic err_seen;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    period_match_timer8 period_match_timer8_i (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq)
    );

    // Clock at 20 MHz.
    always #25 pclk = ~pclk;

    // Cycle counter; reaching the ceiling means something hung.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // Compares a seen value with the expected one.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; holds the request until pready is sampled high.
    // A slave that never answers is caught by the bench cycle ceiling.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(name, rd, {24'h000000, exp});
    endtask : rchk

    // Waits, bounded, until the interrupt line shows the given level.
    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 2000) begin
            check("irq wait", {31'h0, irq}, {31'h0, v});
        end
    endtask : wait_irq

    // Reset values, unmapped access.
    task automatic t_reset();
        rchk("count", ptimer_pkg::OFF_COUNT, 8'h00);
        rchk("period", ptimer_pkg::OFF_PERIOD, 8'hFF);
        rchk("control", ptimer_pkg::OFF_CONTROL, 8'h00);
        rchk("status", ptimer_pkg::OFF_STATUS, 8'h00);
        rchk("mask", ptimer_pkg::OFF_MASK, 8'h00);
        check("irq", {31'h0, irq}, 32'h0);
        apb(1'b0, 8'h14, 32'h00000000);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", {31'h0, err_seen}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    // Register access, bit 7, run enable.
    task automatic t_regs();
        logic [31:0] first;
        wr(ptimer_pkg::OFF_COUNT, 8'h5A);
        rchk("count rw", ptimer_pkg::OFF_COUNT, 8'h5A);
        wr(ptimer_pkg::OFF_PERIOD, 8'h33);
        rchk("period rw", ptimer_pkg::OFF_PERIOD, 8'h33);
        wr(ptimer_pkg::OFF_CONTROL, 8'hFF);
        rchk("control bit7", ptimer_pkg::OFF_CONTROL, 8'h7F);
        wr(ptimer_pkg::OFF_COUNT, 8'h5A);
        wr(ptimer_pkg::OFF_CONTROL, 8'h78);
        rchk("count kept", ptimer_pkg::OFF_COUNT, 8'h5A);
        repeat (20) @(posedge pclk);
        rchk("count stopped", ptimer_pkg::OFF_COUNT, 8'h5A);
        wr(ptimer_pkg::OFF_PERIOD, 8'hFF);
        wr(ptimer_pkg::OFF_CONTROL, 8'h04);
        apb(1'b0, ptimer_pkg::OFF_COUNT, 32'h0);
        first = rd;
        apb(1'b0, ptimer_pkg::OFF_COUNT, 32'h0);
        check("count runs", {31'h0, rd !== first}, 32'h1);
        $display("test regs done");
    endtask : t_regs

    // Count and control writes hold off the scalers; match restarts.
    task automatic t_clear();
        wr(ptimer_pkg::OFF_CONTROL, 8'h00);
        wr(ptimer_pkg::OFF_PERIOD, 8'h01);
        wr(ptimer_pkg::OFF_COUNT, 8'h00);
        wr(ptimer_pkg::OFF_STATUS, 8'h01);
        wr(ptimer_pkg::OFF_CONTROL, 8'h06);
        // Count equals period, so any tick that slipped through would set the flag.
        repeat (12) wr(ptimer_pkg::OFF_COUNT, 8'h01);
        rchk("flag held", ptimer_pkg::OFF_STATUS, 8'h00);
        wr(ptimer_pkg::OFF_COUNT, 8'h01);
        repeat (12) wr(ptimer_pkg::OFF_CONTROL, 8'h06);
        rchk("count after ctl", ptimer_pkg::OFF_COUNT, 8'h01);
        rchk("flag held ctl", ptimer_pkg::OFF_STATUS, 8'h00);
        repeat (12) @(posedge pclk);
        wr(ptimer_pkg::OFF_CONTROL, 8'h00);
        rchk("count restart", ptimer_pkg::OFF_COUNT, 8'h00);
        rchk("flag set", ptimer_pkg::OFF_STATUS, 8'h01);
        $display("test clear done");
    endtask : t_clear

    // Sticky flag, mask, write-one clear.
    task automatic t_irq();
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(ptimer_pkg::OFF_MASK, 8'h01);
        repeat (2) @(posedge pclk);
        check("irq on", {31'h0, irq}, 32'h1);
        wr(ptimer_pkg::OFF_STATUS, 8'h00);
        rchk("flag sticks", ptimer_pkg::OFF_STATUS, 8'h01);
        wr(ptimer_pkg::OFF_STATUS, 8'h01);
        repeat (2) @(posedge pclk);
        check("irq off", {31'h0, irq}, 32'h0);
        rchk("flag clear", ptimer_pkg::OFF_STATUS, 8'h00);
        $display("test irq done");
    endtask : t_irq

    // Interrupt spacing for each prescale code and both postscale ends.
    task automatic t_rate();
        logic [1:0] sel [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
        logic [7:0] per [4] = '{8'h0F, 8'h03, 8'h07, 8'h01};
        logic [3:0] post [4] = '{4'h0, 4'h2, 4'h0, 4'hF};
        int exp [4] = '{16, 48, 128, 512};
        int t1;
        for (int i = 0; i < 4; i++) begin
            wr(ptimer_pkg::OFF_PERIOD, per[i]);
            wr(ptimer_pkg::OFF_CONTROL, {1'b0, post[i], 1'b1, sel[i]});
            wait_irq(1'b1);
            wr(ptimer_pkg::OFF_STATUS, 8'h01);
            wait_irq(1'b0);
            wait_irq(1'b1);
            t1 = cyc;
            wr(ptimer_pkg::OFF_STATUS, 8'h01);
            wait_irq(1'b0);
            wait_irq(1'b1);
            check("flag spacing", cyc - t1, exp[i]);
        end
        wr(ptimer_pkg::OFF_CONTROL, 8'h00);
        $display("test rate done");
    endtask : t_rate

    // Main sequence.
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        t_clear();
        t_irq();
        t_rate();
        stop_test();
    end
endmodule : period_match_timer8_tb
`default_nettype wire
